//--- shared/vin_supervisor_pkg.sv
package vin_supervisor_pkg;

    // command codes of the supervised settings
    localparam logic [7:0]  CMD_OV_WARN      = 8'h57;
    localparam logic [7:0]  CMD_UV_WARN      = 8'h58;
    localparam logic [7:0]  CMD_UV_FAULT     = 8'h59;
    localparam logic [7:0]  CMD_UV_REACT     = 8'h5A;

    // field positions in the fault reaction byte
    localparam int          RESP_HI          = 7;
    localparam int          RESP_LO          = 6;
    localparam int          RETRY_HI         = 5;
    localparam int          RETRY_LO         = 3;
    localparam int          DELAY_HI         = 2;
    localparam int          DELAY_LO         = 0;

    // reset values
    localparam logic [15:0] OV_WARN_RST      = 16'h0000;
    localparam logic [15:0] UV_WARN_RST      = 16'h0000;
    localparam logic [15:0] UV_FAULT_RST     = 16'h0000;
    localparam logic [7:0]  UV_REACT_RST     = 8'hC0;
    localparam logic [15:0] RDATA_RST        = 16'h0000;

    // retry settings with special meaning
    localparam logic [2:0]  RETRY_NONE       = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER    = 3'h7;

    // comparator slots: index 0 looks above its limit, others below
    localparam int          CMP_N            = 3;
    localparam logic [2:0]  CMP_ABOVE        = 3'h1;
    localparam int          CMP_OV_WARN      = 0;
    localparam int          CMP_UV_WARN      = 1;
    localparam int          CMP_UV_FAULT     = 2;

    typedef enum logic [1:0] {
        RESP_IGNORE  = 2'b00,
        RESP_CONT    = 2'b01,
        RESP_RETRY   = 2'b10,
        RESP_LATCH   = 2'b11
    } resp_t;

    typedef enum logic [1:0] {
        ST_RUN       = 2'b00,
        ST_HOLD      = 2'b01,
        ST_WAIT      = 2'b10,
        ST_LATCHED   = 2'b11
    } fsm_t;

endpackage : vin_supervisor_pkg

//--- logic/vin_compare.sv
`timescale 1ns/10ps
`default_nettype none
module vin_compare
#(
    parameter bit ABOVE = 1'b0
)
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // measurement and limit, both linear format
    input  wire logic        meas_valid,
    input  wire logic [15:0] meas,
    input  wire logic [15:0] limit,
    // crossing level, updated on each measurement
    output logic             hit
);
    import vin_supervisor_pkg::*;

    typedef struct packed {
        logic hit;
    } cmp_state_t;

    cmp_state_t q;
    cmp_state_t d;

    // linear value to signed fixed point with 16 fraction bits;
    // exponent + 16 is the 5-bit exponent with its sign bit flipped
    function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
        logic signed [47:0] m;
        logic        [4:0]  sh;
        m = {{37{v[10]}}, v[10:0]};
        sh = {~v[15], v[14:11]};
        lin_fix = m <<< sh;
    endfunction : lin_fix

    // compare only on a fresh sample, hold otherwise
    always_comb
    begin
        d = q;
        if (meas_valid)
        begin
            if (ABOVE)
                d.hit = lin_fix(meas) > lin_fix(limit);
            else
                d.hit = lin_fix(meas) < lin_fix(limit);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign hit = q.hit;

    chk_cmp_hold_between: assert property (@(posedge mclk) disable iff (!rstn)
        !meas_valid |=> $stable(hit))
        else $error("comparator changed without a measurement");

endmodule : vin_compare
`default_nettype wire

//--- logic/vin_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
module vin_delay_timer
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // start request and length
    input  wire logic        start,
    input  wire logic [2:0]  delay_code,
    input  wire logic [15:0] unit_cycles,
    // status
    output logic             busy,
    output logic             done
);
    import vin_supervisor_pkg::*;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [2:0]  code;
        logic [15:0] cyc;
        logic [7:0]  units;
    } tmr_state_t;

    tmr_state_t q;
    tmr_state_t d;
    logic [7:0] last_unit;
    logic       unit_end;

    // 2^code units; a unit length of zero acts as one cycle
    assign last_unit = 8'((9'h001 << q.code) - 9'h001);
    assign unit_end  = (17'(q.cyc) + 17'h00001) >= {1'b0, unit_cycles};

    // a new start restarts the count, so the caller never waits twice
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        if (start)
        begin
            d.busy  = 1'b1;
            d.code  = delay_code;
            d.cyc   = 16'h0000;
            d.units = 8'h00;
        end
        else if (q.busy)
        begin
            if (unit_end)
            begin
                d.cyc = 16'h0000;
                if (q.units == last_unit)
                begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end
                else
                    d.units = q.units + 8'h01;
            end
            else
                d.cyc = q.cyc + 16'h0001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            q <= '0;
        else
            q <= d;
    end

    assign busy = q.busy;
    assign done = q.done;

    chk_timer_single_unit: assert property (@(posedge mclk) disable iff (!rstn)
        (start && delay_code == 3'h0 && unit_cycles == 16'h0001 && !busy)
        |=> busy ##1 (done && !busy))
        else $error("one unit of one cycle did not end after one cycle");

    chk_timer_done_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        done |=> !done)
        else $error("timer done lasted more than one cycle");

endmodule : vin_delay_timer
`default_nettype wire

//--- logic/vin_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - over-voltage warning threshold, 16 bits, host writes and reads it
// - under-voltage warning threshold, also the ratio regulation input threshold
// - ratio regulation uses that threshold only while its enable is set
// - under-voltage fault threshold, 16 bits, detects the input fault
// - response 00: keep running, fault ignored
// - response 01: run for the delay, then retry handling if fault remains
// - response 10: output off at once, then follow retry setting
// - response 11: off until status clear, clear-all, reset or off-on
// - retry 000: no restart, output stays off until cleared
// - retry 1 to 6: that many attempts, then off until cleared
// - attempts spaced by delay count times the delay unit
// - retry 111: endless attempts until commanded off or other shutdown
// - delay field gives two to the field value units, 1 to 128
// - delay unit length comes from a separate setting
// - one delay count serves both continue time and retry spacing
module vin_supervisor
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    // command port of the management bus
    input  wire logic                       cmd_wr,
    input  wire logic                       cmd_rd,
    input  wire logic [7:0]                 cmd_code,
    input  wire logic [15:0]                cmd_wdata,
    output logic [15:0]                     cmd_rdata,
    output logic                            cmd_ack,
    output logic                            cmd_nack,
    // input voltage measurement
    input  wire logic                       meas_valid,
    input  wire logic [15:0]                meas_vin,
    // surrounding control
    input  wire logic [15:0]                delay_unit_cycles,
    input  wire logic                       ratio_enable,
    input  wire logic                       output_on_cmd,
    input  wire logic                       other_fault_shutdown,
    input  wire logic                       clear_faults,
    input  wire logic                       clear_uv_fault_bit,
    // results
    output logic                            output_enable,
    output logic                            ov_warn_flag,
    output logic                            uv_warn_flag,
    output logic                            uv_fault_flag,
    output logic                            ratio_active,
    output vin_supervisor_pkg::fsm_t        fault_state
);
    import vin_supervisor_pkg::*;

    typedef struct packed {
        logic [15:0] ov_warn;
        logic [15:0] uv_warn;
        logic [15:0] uv_fault;
        logic [7:0]  react;
        fsm_t        st;
        logic [2:0]  tries;
        logic        uv_prev;
        logic        ov_flag;
        logic        uvw_flag;
        logic        uvf_flag;
        logic        out_en;
        logic        ratio_act;
        logic        timer_go;
        logic [15:0] rdata;
        logic        ack;
        logic        nack;
    } sup_state_t;

    sup_state_t  q;
    sup_state_t  d;
    logic [15:0] limits [CMP_N];
    logic [2:0]  hits;
    logic        tmr_busy;
    logic        tmr_done;
    logic        uv_new;
    logic        latch_clear;
    resp_t       resp;
    logic [2:0]  retry;
    logic [2:0]  tries_next;

    // reaction fields
    assign resp       = resp_t'(q.react[RESP_HI:RESP_LO]);
    assign retry      = q.react[RETRY_HI:RETRY_LO];
    assign tries_next = q.tries + 3'h1;

    // comparator slots follow the threshold order of the package
    assign limits[CMP_OV_WARN]  = q.ov_warn;
    assign limits[CMP_UV_WARN]  = q.uv_warn;
    assign limits[CMP_UV_FAULT] = q.uv_fault;

    genvar gi;
    generate
        for (gi = 0; gi < CMP_N; gi++)
        begin : g_cmp
            vin_compare
            #(
                .ABOVE      (CMP_ABOVE[gi])
            )
            u_cmp
            (
                .mclk       (mclk),
                .rstn       (rstn),
                .meas_valid (meas_valid),
                .meas       (meas_vin),
                .limit      (limits[gi]),
                .hit        (hits[gi])
            );
        end
    endgenerate

    // one timer serves both the continue time and the retry spacing
    vin_delay_timer u_timer
    (
        .mclk        (mclk),
        .rstn        (rstn),
        .start       (q.timer_go),
        .delay_code  (q.react[DELAY_HI:DELAY_LO]),
        .unit_cycles (delay_unit_cycles),
        .busy        (tmr_busy),
        .done        (tmr_done)
    );

    // a fault is acted on at its onset, not while it merely persists
    assign uv_new      = hits[CMP_UV_FAULT] && !q.uv_prev;
    assign latch_clear = clear_faults || clear_uv_fault_bit || !output_on_cmd;

    always_comb
    begin
        d          = q;
        d.ack      = 1'b0;
        d.nack     = 1'b0;
        d.timer_go = 1'b0;
        d.uv_prev  = hits[CMP_UV_FAULT];

        // command port: thresholds as words, reaction as a byte
        if (cmd_wr)
        begin
            d.ack = 1'b1;
            if (cmd_code == CMD_OV_WARN)
                d.ov_warn = cmd_wdata;
            else if (cmd_code == CMD_UV_WARN)
                d.uv_warn = cmd_wdata;
            else if (cmd_code == CMD_UV_FAULT)
                d.uv_fault = cmd_wdata;
            else if (cmd_code == CMD_UV_REACT)
                d.react = cmd_wdata[7:0];
            else
            begin
                d.ack  = 1'b0;
                d.nack = 1'b1;
            end
        end
        else if (cmd_rd)
        begin
            d.ack = 1'b1;
            if (cmd_code == CMD_OV_WARN)
                d.rdata = q.ov_warn;
            else if (cmd_code == CMD_UV_WARN)
                d.rdata = q.uv_warn;
            else if (cmd_code == CMD_UV_FAULT)
                d.rdata = q.uv_fault;
            else if (cmd_code == CMD_UV_REACT)
                d.rdata = {8'h00, q.react};
            else
            begin
                d.rdata = RDATA_RST;
                d.ack   = 1'b0;
                d.nack  = 1'b1;
            end
        end

        // sticky flags: clear first so a same-cycle crossing wins
        if (clear_faults)
        begin
            d.ov_flag  = 1'b0;
            d.uvw_flag = 1'b0;
            d.uvf_flag = 1'b0;
        end
        if (clear_uv_fault_bit)
            d.uvf_flag = 1'b0;
        if (hits[CMP_OV_WARN])
            d.ov_flag = 1'b1;
        if (hits[CMP_UV_WARN])
            d.uvw_flag = 1'b1;
        if (hits[CMP_UV_FAULT])
            d.uvf_flag = 1'b1;

        // ratio regulation sees the warning threshold only when enabled
        d.ratio_act = ratio_enable && hits[CMP_UV_WARN];

        // fault reaction
        case (q.st)
            ST_RUN:
            begin
                d.tries = 3'h0;
                if (uv_new)
                begin
                    if (resp == RESP_CONT)
                    begin
                        d.st       = ST_HOLD;
                        d.timer_go = 1'b1;
                    end
                    else if (resp == RESP_RETRY)
                    begin
                        if (retry == RETRY_NONE)
                            d.st = ST_LATCHED;
                        else
                        begin
                            d.st       = ST_WAIT;
                            d.timer_go = 1'b1;
                        end
                    end
                    else if (resp == RESP_LATCH)
                        d.st = ST_LATCHED;
                end
            end
            ST_HOLD:
            begin
                // still running; only a persisting fault escalates
                if (tmr_done)
                begin
                    if (!hits[CMP_UV_FAULT])
                        d.st = ST_RUN;
                    else if (retry == RETRY_NONE)
                        d.st = ST_LATCHED;
                    else
                    begin
                        d.st       = ST_WAIT;
                        d.timer_go = 1'b1;
                    end
                end
            end
            ST_WAIT:
            begin
                if (other_fault_shutdown)
                    d.st = ST_LATCHED;
                else if (!output_on_cmd)
                    d.st = ST_RUN;
                else if (tmr_done)
                begin
                    // restart attempt: it fails if the input is still low
                    if (!hits[CMP_UV_FAULT])
                        d.st = ST_RUN;
                    else if (retry == RETRY_FOREVER)
                        d.timer_go = 1'b1;
                    else if (tries_next >= retry)
                        d.st = ST_LATCHED;
                    else
                    begin
                        d.tries    = tries_next;
                        d.timer_go = 1'b1;
                    end
                end
            end
            ST_LATCHED:
            begin
                // an off command releases; turning back on then restarts
                if (latch_clear)
                    d.st = ST_RUN;
            end
            default:
                d.st = ST_LATCHED;
        endcase

        // output runs in normal operation and during the continue time
        d.out_en = output_on_cmd && !other_fault_shutdown
                   && (d.st == ST_RUN || d.st == ST_HOLD);
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            q          <= '0;
            q.ov_warn  <= OV_WARN_RST;
            q.uv_warn  <= UV_WARN_RST;
            q.uv_fault <= UV_FAULT_RST;
            q.react    <= UV_REACT_RST;
            q.st       <= ST_RUN;
            q.rdata    <= RDATA_RST;
        end
        else
            q <= d;
    end

    assign cmd_rdata     = q.rdata;
    assign cmd_ack       = q.ack;
    assign cmd_nack      = q.nack;
    assign output_enable = q.out_en;
    assign ov_warn_flag  = q.ov_flag;
    assign uv_warn_flag  = q.uvw_flag;
    assign uv_fault_flag = q.uvf_flag;
    assign ratio_active  = q.ratio_act;
    assign fault_state   = q.st;

    chk_ignore_keeps_running: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == ST_RUN && resp == RESP_IGNORE && !cmd_wr) |=> q.st == ST_RUN)
        else $error("ignored fault left normal operation");

    chk_cont_stays_on: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == ST_RUN && uv_new && resp == RESP_CONT
         && output_on_cmd && !other_fault_shutdown)
        |=> (q.st == ST_HOLD && output_enable))
        else $error("continue response did not keep output on");

    chk_disable_at_once: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == ST_RUN && uv_new && resp == RESP_RETRY) |=> !output_enable)
        else $error("disable response left output on");

    chk_latch_holds_off: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == ST_LATCHED && !latch_clear) |=> (q.st == ST_LATCHED && !output_enable))
        else $error("latched fault released without a clear");

    chk_no_retry_latch: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == ST_RUN && uv_new && resp == RESP_RETRY && retry == RETRY_NONE)
        |=> q.st == ST_LATCHED)
        else $error("retry setting zero still tried to restart");

    chk_tries_bounded: assert property (@(posedge mclk) disable iff (!rstn)
        (q.st == ST_WAIT && retry != RETRY_FOREVER && retry != RETRY_NONE)
        |-> q.tries < retry)
        else $error("more restart attempts than programmed");

    chk_readback_word: assert property (@(posedge mclk) disable iff (!rstn)
        (cmd_rd && !cmd_wr && cmd_code == CMD_OV_WARN)
        |=> (cmd_ack && cmd_rdata == $past(q.ov_warn)))
        else $error("threshold read did not return the stored word");

    chk_ratio_gated: assert property (@(posedge mclk) disable iff (!rstn)
        !ratio_enable |=> !ratio_active)
        else $error("ratio regulation active while disabled");

endmodule : vin_supervisor
`default_nettype wire

//--- tb/vin_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module vin_host_model
(
    // clock
    input  wire logic        mclk,
    // command port toward the supervisor
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_nack
);
    // bus idle from time zero
    initial
    begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // one strobe cycle, then a bounded wait for ack or nack
    task automatic xfer(input logic wr, input logic [7:0] code,
                        input logic [15:0] wd, output logic [15:0] rd,
                        output logic acked);
        int k;
        @(negedge mclk);
        cmd_wr    = wr;
        cmd_rd    = !wr;
        cmd_code  = code;
        cmd_wdata = wd;
        @(negedge mclk);
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        // inverted leftovers so a stale sample cannot pass
        cmd_code  = ~code;
        cmd_wdata = ~wd;
        k = 0;
        while (cmd_ack !== 1'b1 && cmd_nack !== 1'b1 && k < 4)
        begin
            @(negedge mclk);
            k++;
        end
        acked = (cmd_ack === 1'b1);
        rd    = cmd_rdata;
    endtask : xfer
endmodule : vin_host_model
`default_nettype wire

//--- tb/test_vin_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module test_vin_supervisor;
    import vin_supervisor_pkg::*;
    // design pins
    logic        mclk, rstn, cmd_wr, cmd_rd, cmd_ack, cmd_nack;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, meas_vin, delay_unit_cycles;
    logic        meas_valid, ratio_enable, output_on_cmd;
    logic        other_fault_shutdown, clear_faults, clear_uv_fault_bit;
    logic        output_enable, ov_warn_flag, uv_warn_flag;
    logic        uv_fault_flag, ratio_active;
    fsm_t        fault_state;
    int          miscompares, checks, cyc, n, t;
    localparam logic [15:0] HI = 16'h00C0;
    localparam logic [15:0] LO = 16'h0020;

    vin_host_model host (.mclk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
        .cmd_rdata, .cmd_ack, .cmd_nack);

    vin_supervisor dut (.mclk, .rstn, .cmd_wr, .cmd_rd, .cmd_code,
        .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nack, .meas_valid,
        .meas_vin, .delay_unit_cycles, .ratio_enable, .output_on_cmd,
        .other_fault_shutdown, .clear_faults, .clear_uv_fault_bit,
        .output_enable, .ov_warn_flag, .uv_warn_flag, .uv_fault_flag,
        .ratio_active, .fault_state);

    // 50 MHz clock
    always #10 mclk = ~mclk;

    // hang guard, well above the length of the sequence
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic        a;
        host.xfer(1'b1, c, d, r, a);
        `CHK("write ack", 1'b1, a)
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e,
                          input logic ea);
        logic [15:0] r;
        logic        a;
        host.xfer(1'b0, c, 16'h0000, r, a);
        `CHK("read ack", ea, a)
        `CHK("read data", e, r)
    endtask : rd_chk

    // one measurement pulse, returns after the taking edge
    task automatic sample(input logic [15:0] v);
        @(negedge mclk);
        meas_vin   = v;
        meas_valid = 1'b1;
        @(negedge mclk);
        meas_valid = 1'b0;
    endtask : sample

    task automatic pulse_clear();
        @(negedge mclk);
        clear_faults = 1'b1;
        @(negedge mclk);
        clear_faults = 1'b0;
    endtask : pulse_clear

    // recover, release any latch, load reaction, then a fresh fault onset
    task automatic onset(input logic [7:0] react);
        sample(HI);
        pulse_clear();
        repeat (10) @(negedge mclk);
        wr_reg(CMD_UV_REACT, {8'h00, react});
        sample(LO);
    endtask : onset

    // cycles spent in state s, with bounded waits
    task automatic dwell(input fsm_t s, output int cnt);
        int g;
        g   = 0;
        cnt = 0;
        while (fault_state !== s && g < 8)
        begin
            @(negedge mclk);
            g++;
        end
        while (fault_state === s && cnt < 2000)
        begin
            @(negedge mclk);
            cnt++;
        end
    endtask : dwell

    // main sequence
    initial
    begin
        mclk = 1'b0; rstn = 1'b0; cyc = 0; miscompares = 0; checks = 0;
        meas_valid = 1'b0; meas_vin = HI; delay_unit_cycles = 16'h0002;
        ratio_enable = 1'b0; output_on_cmd = 1'b1; clear_faults = 1'b0;
        other_fault_shutdown = 1'b0; clear_uv_fault_bit = 1'b0;
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        // reset values, then word and byte access, unmapped code
        for (int i = 0; i < 4; i++)
            rd_chk(8'(CMD_OV_WARN + i), (i == 3) ? 16'h00C0 : 16'h0000, 1);
        wr_reg(CMD_OV_WARN, 16'hA5C3);
        rd_chk(CMD_OV_WARN, 16'hA5C3, 1'b1);
        wr_reg(CMD_UV_WARN, 16'h5A3C);
        rd_chk(CMD_UV_WARN, 16'h5A3C, 1'b1);
        wr_reg(CMD_UV_FAULT, 16'hC35A);
        rd_chk(CMD_UV_FAULT, 16'hC35A, 1'b1);
        wr_reg(CMD_UV_REACT, 16'hFF93);
        rd_chk(CMD_UV_REACT, 16'h0093, 1'b1);
        rd_chk(8'h5B, 16'h0000, 1'b0);
        `CHK("read nack", 1'b1, cmd_nack)
        wr_reg(CMD_OV_WARN, 16'h0100);
        wr_reg(CMD_UV_WARN, 16'h0080);
        wr_reg(CMD_UV_FAULT, 16'h0040);
        // threshold crossings
        sample(16'h0200);
        repeat (3) @(negedge mclk);
        `CHK("ov flag", 1'b1, ov_warn_flag)
        pulse_clear();
        sample(16'h0060);
        repeat (3) @(negedge mclk);
        `CHK("uv warn", 1'b1, uv_warn_flag)
        `CHK("uv fault", 1'b0, uv_fault_flag)
        `CHK("ratio off", 1'b0, ratio_active)
        ratio_enable = 1'b1;
        sample(16'h0060);
        repeat (3) @(negedge mclk);
        `CHK("ratio on", 1'b1, ratio_active)
        ratio_enable = 1'b0;
        // ignore response
        onset(8'h00);
        repeat (3) @(negedge mclk);
        `CHK("uv fault", 1'b1, uv_fault_flag)
        `CHK("ign out", 1'b1, output_enable)
        `CHK("ign st", ST_RUN, fault_state)
        // continue for the delay, then no retry; one-cycle units here
        delay_unit_cycles = 16'h0001;
        for (int d = 0; d < 3; d++)
        begin
            onset(8'h40 | 8'(d));
            dwell(ST_HOLD, n);
            t = 1 << d;
            `CHK("hold len", 1'b1, n >= t && n <= t + 4)
            repeat (3) @(negedge mclk);
            `CHK("hold end", ST_LATCHED, fault_state)
            `CHK("hold out", 1'b0, output_enable)
        end
        // latch until cleared, two ways of release
        delay_unit_cycles = 16'h0002;
        onset(8'hC0);
        repeat (40) @(negedge mclk);
        `CHK("latch st", ST_LATCHED, fault_state)
        `CHK("latch out", 1'b0, output_enable)
        clear_uv_fault_bit = 1'b1;
        @(negedge mclk);
        clear_uv_fault_bit = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("bit clr", 1'b1, output_enable)
        onset(8'hC0);
        repeat (5) @(negedge mclk);
        output_on_cmd = 1'b0;
        repeat (3) @(negedge mclk);
        output_on_cmd = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("offon clr", 1'b1, output_enable)
        // disable and retry N times, spacing of two units
        for (int r = 1; r < 4; r++)
        begin
            onset(8'h81 | 8'(r << 3));
            repeat (3) @(negedge mclk);
            `CHK("retry out", 1'b0, output_enable)
            dwell(ST_WAIT, n);
            t = r * 4;
            `CHK("retry len", 1'b1, n + 3 >= t && n <= t + 3 * r + 4)
            `CHK("retry end", ST_LATCHED, fault_state)
        end
        // endless retry, stopped by other fault and by off command
        onset(8'hB9);
        repeat (100) @(negedge mclk);
        `CHK("forever st", ST_WAIT, fault_state)
        `CHK("forever out", 1'b0, output_enable)
        other_fault_shutdown = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("other stop", ST_LATCHED, fault_state)
        other_fault_shutdown = 1'b0;
        onset(8'hB9);
        repeat (20) @(negedge mclk);
        output_on_cmd = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("off stop", ST_RUN, fault_state)
        output_on_cmd = 1'b1;
        conclude();
    end
endmodule : test_vin_supervisor
`default_nettype wire
